// [core/synth_pkg.sv]
// Package with register map, field layout and timing constants of the synthesizer control block.
package synth_pkg;
  localparam logic [15:0] ADDR_LOCK_CFG_STATUS_CHANNEL_FREQUENCY_WORD_HIGH = 16'hDF10;
  localparam logic [15:0] ADDR_CHANNEL_FREQUENCY_WORD_LOW = 16'hDF11;
  localparam logic [15:0] ADDR_SYNTH_CTRL = 16'hDF18;
  localparam int THR_MSB = 7;
  localparam int THR_LSB = 6;
  localparam int CAL_DONE_BIT = 5;
  localparam int CAL_RUNNING_BIT = 4;
  localparam int LOCK_LENGTH_BIT = 3;
  localparam int LOCK_STATUS_BIT = 2;
  localparam int CHANNEL_FREQUENCY_WORD_HIGH_MSB = 1;
  localparam int SYNTH_ON_BIT = 0;
  localparam int RX_EN_BIT = 1;
  localparam int CAL_START_BIT = 2;
  localparam logic [1:0] THR_RESET = 2'h1;
  localparam logic [1:0] CHANNEL_FREQUENCY_WORD_HIGH_RESET = 2'h1;
  localparam logic [7:0] CHANNEL_FREQUENCY_WORD_LOW_RESET = 8'h65;
  localparam logic [11:0] CHANNEL_FREQUENCY_WORD_BASE = 12'h800;
  localparam logic [11:0] RX_LO_OFFSET = 12'h002;
  localparam logic [2:0] WINDOW_SHORT = 3'h2;
  localparam logic [2:0] WINDOW_LONG = 3'h4;
  localparam logic [9:0] THR_64 = 10'h040;
  localparam logic [9:0] THR_128 = 10'h080;
  localparam logic [9:0] THR_256 = 10'h100;
  localparam logic [9:0] THR_512 = 10'h200;
  localparam int CAL_CYCLES = 16;
  typedef enum logic [1:0] {
    CAL_IDLE = 2'b00,
    CAL_BUSY = 2'b01,
    CAL_DONE = 2'b10
  } cal_state_t;
endpackage

// [core/lock_bus_if.sv]
// Interface carrying lock detector configuration and status between modules.
`timescale 1ns/100ps
`default_nettype none
interface lock_bus_if;
  logic [1:0] threshold_code;
  logic window_long;
  logic enable;
  logic window_pulse;
  logic locked;
  modport ctrl (output threshold_code, output window_long, output enable, input window_pulse,
    input locked);
  modport det (input threshold_code, input window_long, input enable, output window_pulse,
    output locked);
endinterface
`default_nettype wire

// [core/lock_detector.sv]
// Lock detector: sync window pulse generation and consecutive-success counting.
`timescale 1ns/100ps
`default_nettype none
module lock_detector (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ref_tick,
  input wire logic pre_tick,
  input wire logic window_ok,
  lock_bus_if.det bus
);
  import synth_pkg::*;

  logic [2:0] win_cnt;
  logic [2:0] next_win_cnt;
  logic [9:0] run_cnt;
  logic [9:0] next_run_cnt;
  logic locked_q;
  logic next_locked;
  logic [9:0] thr;

  // Decodes the two-bit threshold code into a period count.
  function automatic logic [9:0] thr_decode(input logic [1:0] code);
    case (code)
      2'b00: thr_decode = THR_64;
      2'b01: thr_decode = THR_128;
      2'b10: thr_decode = THR_256;
      default: thr_decode = THR_512;
    endcase
  endfunction

  // Window opens on each reference tick and lasts 2 or 4 prescaler periods.
  always_comb begin
    thr = thr_decode(bus.threshold_code); // RULE_01
    next_win_cnt = win_cnt;
    if (!bus.enable) begin
      next_win_cnt = 3'h0;
    end else if (ref_tick) begin
      next_win_cnt = bus.window_long ? WINDOW_LONG : WINDOW_SHORT; // RULE_03
    end else if (pre_tick && win_cnt != 3'h0) begin
      next_win_cnt = win_cnt - 3'h1;
    end
    // Any failed window drops the run, so only an unbroken run can reach the threshold.
    next_run_cnt = run_cnt;
    next_locked = locked_q;
    if (!bus.enable) begin
      next_run_cnt = 10'h000;
      next_locked = 1'b0;
    end else if (ref_tick) begin
      if (!window_ok) begin
        next_run_cnt = 10'h000; // RULE_08
        next_locked = 1'b0;
      end else if (run_cnt >= thr - 10'h001) begin
        next_locked = 1'b1; // RULE_01
        next_run_cnt = thr;
      end else begin
        next_run_cnt = run_cnt + 10'h001;
      end
    end
  end

  // State registers.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      win_cnt <= 3'h0;
      run_cnt <= 10'h000;
      locked_q <= 1'b0;
    end else begin
      win_cnt <= next_win_cnt;
      run_cnt <= next_run_cnt;
      locked_q <= next_locked;
    end
  end

  assign bus.window_pulse = (win_cnt != 3'h0);
  assign bus.locked = locked_q;
endmodule
`default_nettype wire

// [core/synth_lock_and_channel_ctrl.sv]
// Synthesizer control: channel word, oscillator dividers, lock and calibration status.
// Operation
// RULE_01: Lock asserts after 64, 128, 256 or 512 good reference periods per code.
// RULE_02: Read-only lock status bit 2 reads 1 while locked, else 0.
// RULE_03: Sync window pulse lasts 2 prescaler periods, or 4 when length set.
// RULE_04: Calibration-done clears at synthesizer power-on, sets when calibration completes.
// RULE_05: Read-only calibration-running bit 4 is 1 only during calibration.
// RULE_06: Transmit carrier is 2048 plus word in MHz; divider is that over four (in receive the code divides the 2 MHz lower oscillator frequency).
// RULE_07: Receive oscillator sits 2 MHz below carrier while receiver enabled.
// RULE_08: A failed sync window restarts the consecutive success count from zero.
`timescale 1ns/100ps
`default_nettype none
module synth_lock_and_channel_ctrl #(
  parameter int CAL_LEN = synth_pkg::CAL_CYCLES
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [15:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic ref_tick,
  input wire logic pre_tick,
  input wire logic window_ok,
  output logic lock_window,
  output logic synth_on,
  output logic receiver_enabled,
  output logic [11:0] osc_channel_frequency_word_mhz,
  output logic [9:0] osc_divide
);
  import synth_pkg::*;

  // Oscillator outputs at reset follow the reset channel word in transmit.
  localparam logic [11:0] CHANNEL_FREQUENCY_WORD_AT_RESET = CHANNEL_FREQUENCY_WORD_BASE + {2'h0, CHANNEL_FREQUENCY_WORD_HIGH_RESET, CHANNEL_FREQUENCY_WORD_LOW_RESET};
  localparam logic [9:0] DIV_AT_RESET = CHANNEL_FREQUENCY_WORD_AT_RESET[11:2];

  lock_bus_if lbus ();

  // Software-visible configuration fields.
  logic [1:0] lock_count_threshold;
  logic lock_length;
  logic [9:0] channel_frequency_word;

  // Next values of the register group.
  logic [7:0] next_rdata;
  logic [1:0] next_thr;
  logic next_len;
  logic [9:0] next_word;
  logic next_on;
  logic next_rx;
  logic cal_req;

  // Calibration sequencer state.
  cal_state_t cal_state;
  cal_state_t next_cal_state;
  logic [15:0] cal_cnt;
  logic [15:0] next_cal_cnt;
  logic cal_done_flag;
  logic next_cal_done_flag;

  // Next values of the oscillator settings and the window output.
  logic [11:0] next_channel_frequency_word;
  logic [9:0] next_div;
  logic next_window;

  // Window timing and run counting live in their own module, fed through the interface.
  lock_detector u_det (
    .clk(clk),
    .arst_n(arst_n),
    .ref_tick(ref_tick),
    .pre_tick(pre_tick),
    .window_ok(window_ok),
    .bus(lbus.det)
  );

  // The detector is held idle, with lock cleared, while the synthesizer is off.
  assign lbus.threshold_code = lock_count_threshold;
  assign lbus.window_long = lock_length;
  assign lbus.enable = synth_on;

  // Register writes and read mux; unmapped addresses read zero and ignore writes.
  always_comb begin
    next_thr = lock_count_threshold;
    next_len = lock_length;
    next_word = channel_frequency_word;
    next_on = synth_on;
    next_rx = receiver_enabled;
    cal_req = 1'b0;
    next_rdata = 8'h00;
    if (wr) begin
      case (addr)
        ADDR_LOCK_CFG_STATUS_CHANNEL_FREQUENCY_WORD_HIGH: begin
          next_thr = wdata[THR_MSB:THR_LSB];
          next_len = wdata[LOCK_LENGTH_BIT];
          next_word[9:8] = wdata[CHANNEL_FREQUENCY_WORD_HIGH_MSB:0];
        end
        ADDR_CHANNEL_FREQUENCY_WORD_LOW: begin
          next_word[7:0] = wdata;
        end
        ADDR_SYNTH_CTRL: begin
          // Calibration start is a pulse; it only counts when the same write sets the synthesizer on bit.
          next_on = wdata[SYNTH_ON_BIT];
          next_rx = wdata[RX_EN_BIT];
          cal_req = wdata[CAL_START_BIT] & wdata[SYNTH_ON_BIT];
        end
        default: begin
          next_on = synth_on;
        end
      endcase
    end
    if (rd) begin
      case (addr)
        ADDR_LOCK_CFG_STATUS_CHANNEL_FREQUENCY_WORD_HIGH: begin
          next_rdata[THR_MSB:THR_LSB] = lock_count_threshold;
          next_rdata[CAL_DONE_BIT] = cal_done_flag;
          next_rdata[CAL_RUNNING_BIT] = (cal_state == CAL_BUSY); // RULE_05
          next_rdata[LOCK_LENGTH_BIT] = lock_length;
          next_rdata[LOCK_STATUS_BIT] = lbus.locked; // RULE_02
          next_rdata[CHANNEL_FREQUENCY_WORD_HIGH_MSB:0] = channel_frequency_word[9:8];
        end
        ADDR_CHANNEL_FREQUENCY_WORD_LOW: begin
          next_rdata = channel_frequency_word[7:0];
        end
        ADDR_SYNTH_CTRL: begin
          next_rdata[SYNTH_ON_BIT] = synth_on;
          next_rdata[RX_EN_BIT] = receiver_enabled;
        end
        default: begin
          next_rdata = 8'h00;
        end
      endcase
    end
  end

  // Calibration sequencer; a power-on edge clears done, completion sets it.
  always_comb begin
    next_cal_state = cal_state;
    next_cal_cnt = cal_cnt;
    next_cal_done_flag = cal_done_flag;
    if (next_on && !synth_on) begin
      next_cal_done_flag = 1'b0; // RULE_04
    end
    case (cal_state)
      CAL_IDLE, CAL_DONE: begin
        if (cal_req) begin
          next_cal_state = CAL_BUSY; // RULE_05
          next_cal_cnt = 16'h0000;
        end
      end
      CAL_BUSY: begin
        // Turning the synthesizer off abandons a calibration; done keeps its value.
        if (!next_on) begin
          next_cal_state = CAL_IDLE;
        end else if (cal_cnt == 16'(CAL_LEN - 1)) begin
          next_cal_state = CAL_DONE;
          next_cal_done_flag = 1'b1; // RULE_04
        end else begin
          next_cal_cnt = cal_cnt + 16'h0001;
        end
      end
      default: begin
        next_cal_state = CAL_IDLE;
      end
    endcase
  end

  // Oscillator frequency: carrier in transmit, 2 MHz lower in receive.
  // The divider follows the frequency actually produced, so receive divides the lower value.
  always_comb begin
    next_channel_frequency_word = CHANNEL_FREQUENCY_WORD_BASE + {2'h0, next_word}; // RULE_06
    if (next_rx) begin
      next_channel_frequency_word = next_channel_frequency_word - RX_LO_OFFSET; // RULE_07
    end
    next_div = next_channel_frequency_word[11:2]; // RULE_06
    next_window = lbus.window_pulse; // RULE_03
  end

  // Register group: configuration fields and read data.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      lock_count_threshold <= THR_RESET;
      lock_length <= 1'b0;
      channel_frequency_word <= {CHANNEL_FREQUENCY_WORD_HIGH_RESET, CHANNEL_FREQUENCY_WORD_LOW_RESET};
      synth_on <= 1'b0;
      receiver_enabled <= 1'b0;
      rdata <= 8'h00;
    end else begin
      lock_count_threshold <= next_thr;
      lock_length <= next_len;
      channel_frequency_word <= next_word;
      synth_on <= next_on;
      receiver_enabled <= next_rx;
      rdata <= next_rdata;
    end
  end

  // Calibration group.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cal_state <= CAL_IDLE;
      cal_cnt <= 16'h0000;
      cal_done_flag <= 1'b0;
    end else begin
      cal_state <= next_cal_state;
      cal_cnt <= next_cal_cnt;
      cal_done_flag <= next_cal_done_flag;
    end
  end

  // Output group: oscillator settings and window, each straight from a flip-flop.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      osc_channel_frequency_word_mhz <= CHANNEL_FREQUENCY_WORD_AT_RESET;
      osc_divide <= DIV_AT_RESET;
      lock_window <= 1'b0;
    end else begin
      osc_channel_frequency_word_mhz <= next_channel_frequency_word;
      osc_divide <= next_div;
      lock_window <= next_window;
    end
  end
endmodule
`default_nettype wire

// [sim/synth_props.sv]
// Checker for the synthesizer control ports.
`timescale 1ns/100ps
`default_nettype none
module synth_props import synth_pkg::*; #(
  parameter int CAL_LEN = 16
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [15:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic ref_tick,
  input wire logic pre_tick,
  input wire logic window_ok,
  input wire logic lock_window,
  input wire logic synth_on,
  input wire logic receiver_enabled,
  input wire logic [11:0] osc_channel_frequency_word_mhz,
  input wire logic [9:0] osc_divide
);
  int run;
  int next_run;
  // Unbroken run of good windows; a shown lock can never be ahead of it.
  always_comb begin
    next_run = run;
    if (!synth_on || (ref_tick && !window_ok)) next_run = 0;
    else if (ref_tick) next_run = run + 1;
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) run <= 0;
    else run <= next_run;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  sequence s_rd_hi; rd && addr == ADDR_LOCK_CFG_STATUS_CHANNEL_FREQUENCY_WORD_HIGH; endsequence
  sequence s_off_rd; !synth_on [*2] ##0 s_rd_hi; endsequence
  sequence s_go; wr && addr == ADDR_SYNTH_CTRL && wdata[SYNTH_ON_BIT] && wdata[CAL_START_BIT];
  endsequence
  property p_div; osc_divide == osc_channel_frequency_word_mhz[11:2]; endproperty
  property p_floor; !receiver_enabled |-> osc_channel_frequency_word_mhz >= CHANNEL_FREQUENCY_WORD_BASE; endproperty
  property p_win; $rose(lock_window) |-> $past(ref_tick) || $past(ref_tick, 2) || $past(ref_tick, 3);
  endproperty
  property p_run; s_rd_hi |=> !rdata[LOCK_STATUS_BIT] || $past(run) >= 64; endproperty
  property p_lock_off; s_off_rd |=> !rdata[LOCK_STATUS_BIT]; endproperty
  property p_cal_off; s_off_rd |=> !rdata[CAL_RUNNING_BIT]; endproperty
  property p_cal_run; s_go ##0 synth_on ##2 synth_on ##0 s_rd_hi |=> rdata[CAL_RUNNING_BIT];
  endproperty
  property p_done_clr; $rose(synth_on) ##1 s_rd_hi |=> !rdata[CAL_DONE_BIT]; endproperty
  // A stale divider or an offset applied without the receiver shows in these two first.
  a_div: assert property (p_div) else $error("divider off");
  a_floor: assert property (p_floor) else $error("offset without receiver");
  a_win: assert property (p_win) else $error("window without tick");
  a_run: assert property (p_run) else $error("lock too early");
  a_lock_off: assert property (p_lock_off) else $error("lock while off");
  a_cal_off: assert property (p_cal_off) else $error("running while off");
  a_cal_run: assert property (p_cal_run) else $error("not running");
  a_done_clr: assert property (p_done_clr) else $error("done kept");
endmodule
bind synth_lock_and_channel_ctrl synth_props #(.CAL_LEN(CAL_LEN)) props (.clk(clk),
  .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .ref_tick(ref_tick), .pre_tick(pre_tick), .window_ok(window_ok), .lock_window(lock_window),
  .synth_on(synth_on), .receiver_enabled(receiver_enabled), .osc_channel_frequency_word_mhz(osc_channel_frequency_word_mhz),
  .osc_divide(osc_divide));
`default_nettype wire

// [sim/pll_model.sv]
// Model of the analog loop: reference and prescaler ticks and window outcome.
`timescale 1ns/100ps
`default_nettype none
module pll_model (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic bad,
  output logic ref_tick,
  output logic pre_tick,
  output logic window_ok
);
  logic [4:0] cnt;
  // Reference every 24 cycles, prescaler every 4; the long window still fits.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) cnt <= 5'h00;
    else cnt <= (cnt == 5'h17) ? 5'h00 : cnt + 5'h01;
  end
  // Outcome is only meaningful on a tick; elsewhere it toggles to expose misuse.
  assign ref_tick = cnt == 5'h00;
  assign pre_tick = cnt[1:0] == 2'h2;
  assign window_ok = ref_tick ? !bad : cnt[0];
endmodule
`default_nettype wire

// [sim/tb_top.sv]
// Self-checking bench for the synthesizer control block.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import synth_pkg::*;
  localparam logic [15:0] HI = ADDR_LOCK_CFG_STATUS_CHANNEL_FREQUENCY_WORD_HIGH;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic bad = 1'b0;
  logic [7:0] rdata;
  logic ref_tick, pre_tick, window_ok, lock_window, synth_on, receiver_enabled;
  logic [11:0] osc_channel_frequency_word_mhz;
  logic [9:0] osc_divide;
  int fail_count = 0;
  int num_checks = 0;
  int cycles = 0;
  int w;
  // Rows: receive flag, frequency word (2 or more) and the oscillator frequency it must give.
  logic [22:0] rows [5] = '{23'h402800, 23'h3FFBFF, 23'h7FFBFD, 23'h165965, 23'h6009FE};
  synth_lock_and_channel_ctrl #(.CAL_LEN(4)) dut (.clk(clk), .arst_n(arst_n), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .ref_tick(ref_tick), .pre_tick(pre_tick),
    .window_ok(window_ok), .lock_window(lock_window), .synth_on(synth_on),
    .receiver_enabled(receiver_enabled), .osc_channel_frequency_word_mhz(osc_channel_frequency_word_mhz), .osc_divide(osc_divide));
  pll_model far (.clk(clk), .arst_n(arst_n), .bad(bad), .ref_tick(ref_tick),
    .pre_tick(pre_tick), .window_ok(window_ok));
  initial begin
    forever #2.5 clk = ~clk;
  end
  task automatic chk(input logic [11:0] got, input logic [11:0] e);
    num_checks++;
    if (got !== e) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, e);
    end
  endtask
  // Strobes drop before the next request, so no signal is driven twice in a step.
  task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd_reg(input logic [15:0] a, input logic [7:0] m, input logic [7:0] e);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk({4'h0, rdata & m}, {4'h0, e});
    @(posedge clk);
  endtask
  task automatic ticks(input int n);
    repeat (n) @(posedge clk iff ref_tick);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Whole run needs about 26000 cycles; the ceiling leaves a wide margin.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      fail_count++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    chk(osc_channel_frequency_word_mhz, CHANNEL_FREQUENCY_WORD_BASE + 12'h165);
    rd_reg(HI, 8'hFF, 8'h41);
    wr_reg(16'hDF1F, 8'hAA);
    rd_reg(16'hDF1F, 8'hFF, 8'h00);
    rd_reg(ADDR_CHANNEL_FREQUENCY_WORD_LOW, 8'hFF, CHANNEL_FREQUENCY_WORD_LOW_RESET);
    wr_reg(ADDR_SYNTH_CTRL, 8'h01);
    foreach (rows[i]) begin
      wr_reg(HI, {6'h00, rows[i][21:20]});
      wr_reg(ADDR_CHANNEL_FREQUENCY_WORD_LOW, rows[i][19:12]);
      wr_reg(ADDR_SYNTH_CTRL, {6'h00, rows[i][22], 1'b1});
      repeat (3) @(posedge clk);
      chk(osc_channel_frequency_word_mhz, rows[i][11:0]);
      chk({2'h0, osc_divide}, {2'h0, rows[i][11:2]});
      chk({10'h000, receiver_enabled, synth_on}, {10'h000, rows[i][22], 1'b1});
    end
    for (int n = 0; n < 2; n++) begin
      wr_reg(HI, {4'h0, n[0], 3'h1});
      ticks(1);
      w = 0;
      repeat (23) begin
        @(negedge clk);
        w += int'(lock_window);
      end
      chk(w[11:0], {9'h0, n[0] ? WINDOW_LONG : WINDOW_SHORT} * 12'h004 - 12'h002);
    end
    for (int c = 0; c < 4; c++) begin
      wr_reg(ADDR_SYNTH_CTRL, 8'h00);
      wr_reg(HI, {c[1:0], 6'h01});
      ticks(1);
      wr_reg(ADDR_SYNTH_CTRL, 8'h01);
      ticks((64 << c) - 1);
      rd_reg(HI, 8'h04, 8'h00);
      ticks(1);
      rd_reg(HI, 8'h04, 8'h04);
    end
    wr_reg(ADDR_SYNTH_CTRL, 8'h00);
    rd_reg(HI, 8'h04, 8'h00);
    wr_reg(HI, 8'h01);
    ticks(1);
    wr_reg(ADDR_SYNTH_CTRL, 8'h01);
    ticks(40);
    bad <= 1'b1;
    ticks(1);
    bad <= 1'b0;
    ticks(63);
    rd_reg(HI, 8'h04, 8'h00);
    ticks(1);
    rd_reg(HI, 8'h04, 8'h04);
    wr_reg(ADDR_SYNTH_CTRL, 8'h05);
    rd_reg(HI, 8'h30, 8'h10);
    repeat (8) @(posedge clk);
    rd_reg(HI, 8'h30, 8'h20);
    wr_reg(ADDR_SYNTH_CTRL, 8'h00);
    wr_reg(ADDR_SYNTH_CTRL, 8'h04);
    rd_reg(HI, 8'h30, 8'h20);
    wr_reg(ADDR_SYNTH_CTRL, 8'h01);
    rd_reg(HI, 8'h30, 8'h00);
    tally_and_finish();
  end
endmodule
`default_nettype wire
